//--- adc_board_defines.svh
// constant macros for the analog input board: addresses, register layout, timing
`ifndef ADC_BOARD_DEFINES_SVH
`define ADC_BOARD_DEFINES_SVH

// ****************************************
// bus window
// ****************************************
`define WINDOW_HIGH_BYTE     8'h81
`define WINDOW_A7_A6         2'h1
`define WINDOW_FIRST         16'h8140
`define WINDOW_LAST          16'h817F

// ****************************************
// register offsets and fields
// ****************************************
`define OFS_RESULT_LOW       2'h0
`define OFS_FIRST_CTRL       2'h1
`define OFS_RESULT_HIGH_SEL  2'h2
`define OFS_SECOND_CTRL      2'h3
`define CTRL_DATA_SEL_BIT    2
`define CTRL_GO_BIT          3
`define CTRL_OE_BIT          3
`define CTRL_FLAG_BIT        7
`define CTRL_RESET           8'h00
`define SEL_RESET            8'h00
`define SEL_COMP_FIRST       5'h10
`define MUX_COUNT            5
`define CHANNELS_PER_BOARD   8'h10

// ****************************************
// converter timing
// ****************************************
`define CLK_PERIOD_NS        50
`define CONV_FAST_NS         2000
`define CONV_SLOW_NS         4000
`define CONV_FAST_CYCLES     7'((`CONV_FAST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_SLOW_CYCLES     7'((`CONV_SLOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PHASE_SHORT_LAST     13'h00FF
`define PHASE_MIDPOINT       13'h0080
`define RAMP_UNKNOWN_LAST    13'h0FFF
`define RAMP_REF_LAST        13'h1FFF
`define RESULT_FULL          12'hFFF

`endif

//--- adc_board_pkg.sv
// types shared by the analog input board modules
package adc_board_pkg;

	typedef enum logic [2:0] {
		PH_IDLE,
		PH_OFFSET,
		PH_POLARITY,
		PH_INIT,
		PH_RAMP_UNKNOWN,
		PH_RAMP_REFERENCE
	} phase_t;

endpackage : adc_board_pkg

//--- adc_sequencer.sv
// five-phase integrating converter controller
`timescale 1ns/100ps
`include "adc_board_defines.svh"

module adc_sequencer (
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        slow_i,
	input  wire logic        go_i,
	input  wire logic        oe_n_i,
	input  wire logic        comp_i,
	output logic             offset_null_phase_o,
	output logic             polarity_or_ramp_pos_o,
	output logic             ramp_neg_o,
	output logic             ramp_back_active_o,
	output logic             done_o,
	output logic [11:0]      result_o,
	output logic             over_o,
	output logic             polarity_o
);

	adc_board_pkg::phase_t phase_q, phase_d;
	logic [6:0]  div_q, div_d;
	logic [12:0] cnt_q, cnt_d;
	logic        pos_q, pos_d;
	logic        tick;
	logic        on_q, on_d, rp_q, rp_d, rn_q, rn_d, rr_q, rr_d, done_q, done_d;
	logic [11:0] res_q, res_d;
	logic        over_q, over_d, pol_q, pol_d;

	// ****************************************
	// converter clock
	// ****************************************
	assign tick = (div_q == 7'h00);

	always_comb begin
		// jumper picks a 2 us or 4 us converter period
		if (tick) begin
			div_d = (slow_i ? `CONV_SLOW_CYCLES : `CONV_FAST_CYCLES) - 7'h01;
		end else begin
			div_d = div_q - 7'h01;
		end
	end

	// ****************************************
	// phase sequence
	// ****************************************
	always_comb begin
		phase_d = phase_q;
		cnt_d   = cnt_q;
		pos_d   = pos_q;
		res_d   = res_q;
		over_d  = over_q;
		pol_d   = pol_q;
		done_d  = done_q;
		if (tick) begin
			cnt_d = cnt_q + 13'h0001;
			unique case (phase_q)
				adc_board_pkg::PH_IDLE: begin
					cnt_d = 13'h0000;
					if (go_i && oe_n_i) begin
						phase_d = adc_board_pkg::PH_OFFSET;
						done_d  = 1'b0;
					end
				end
				adc_board_pkg::PH_OFFSET: begin
					if (cnt_q == `PHASE_SHORT_LAST) begin
						phase_d = adc_board_pkg::PH_POLARITY;
						cnt_d   = 13'h0000;
					end
				end
				adc_board_pkg::PH_POLARITY: begin
					if (cnt_q == `PHASE_MIDPOINT) begin
						pos_d = comp_i;
					end
					if (cnt_q == `PHASE_SHORT_LAST) begin
						phase_d = adc_board_pkg::PH_INIT;
						cnt_d   = 13'h0000;
					end
				end
				adc_board_pkg::PH_INIT: begin
					if (cnt_q == `PHASE_SHORT_LAST) begin
						phase_d = adc_board_pkg::PH_RAMP_UNKNOWN;
						cnt_d   = 13'h0000;
					end
				end
				adc_board_pkg::PH_RAMP_UNKNOWN: begin
					if (cnt_q == `RAMP_UNKNOWN_LAST) begin
						phase_d = adc_board_pkg::PH_RAMP_REFERENCE;
						cnt_d   = 13'h0000;
					end
				end
				adc_board_pkg::PH_RAMP_REFERENCE: begin
					if (!comp_i || cnt_q == `RAMP_REF_LAST) begin
						phase_d = adc_board_pkg::PH_IDLE;
						cnt_d   = 13'h0000;
						// counts past the 12-bit range saturate and flag over-range
						over_d  = cnt_q[12];
						res_d   = cnt_q[12] ? `RESULT_FULL : cnt_q[11:0];
						pol_d   = pos_q;
						done_d  = 1'b1;
					end
				end
			endcase
		end
	end

	// ****************************************
	// analog block controls
	// ****************************************
	always_comb begin
		on_d = (phase_d == adc_board_pkg::PH_OFFSET) || (phase_d == adc_board_pkg::PH_INIT);
		rp_d = (phase_d == adc_board_pkg::PH_POLARITY) ||
		       (phase_d == adc_board_pkg::PH_RAMP_UNKNOWN && pos_d);
		rn_d = (phase_d == adc_board_pkg::PH_RAMP_UNKNOWN) && !pos_d;
		rr_d = (phase_d == adc_board_pkg::PH_RAMP_REFERENCE);
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			phase_q <= adc_board_pkg::PH_IDLE;
			div_q   <= 7'h00;
			cnt_q   <= 13'h0000;
			pos_q   <= 1'b0;
			res_q   <= 12'h000;
			over_q  <= 1'b0;
			pol_q   <= 1'b0;
			done_q  <= 1'b0;
			on_q    <= 1'b0;
			rp_q    <= 1'b0;
			rn_q    <= 1'b0;
			rr_q    <= 1'b0;
		end else begin
			phase_q <= phase_d;
			div_q   <= div_d;
			cnt_q   <= cnt_d;
			pos_q   <= pos_d;
			res_q   <= res_d;
			over_q  <= over_d;
			pol_q   <= pol_d;
			done_q  <= done_d;
			on_q    <= on_d;
			rp_q    <= rp_d;
			rn_q    <= rn_d;
			rr_q    <= rr_d;
		end
	end

	assign offset_null_phase_o    = on_q;
	assign polarity_or_ramp_pos_o = rp_q;
	assign ramp_neg_o             = rn_q;
	assign ramp_back_active_o     = rr_q;
	assign done_o                 = done_q;
	assign result_o               = res_q;
	assign over_o                 = over_q;
	assign polarity_o             = pol_q;

endmodule : adc_sequencer

//--- analog_input_board.sv
// analog input board: bus decode, peripheral adapter registers and converter control
//
// Behaviour
// - four addresses in 8140..817F, switch picks slot
// - switch XOR address, combined with window select
// - match gives active-high board select
// - buffers face CPU on read, adapter on write
// - port A carries result low byte
// - port B carries result high nibble, over-range
// - port B outputs select one of twenty inputs
// - inputs 17..20 are compensation, not user
// - board number sets sixteen-channel group
// - converter period 2 us, or 4 us by jumper
// - five ordered conversion phases
// - go plus output-enable line start 256-clock offset
// - polarity phase high, comparator sampled midway
// - initialization repeats offset null 256 clocks
// - ramp unknown 4096 clocks, one direction only
// - ramp reference ends on comparator or 8192
// - result keeps polarity, holds until next done
// - result driven only with enable low, go high
// - four controls out, one comparator in
// - integrating conversion, 12-bit magnitude
`timescale 1ns/100ps
`include "adc_board_defines.svh"

module analog_input_board (
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic [15:0] addr_i,
	input  wire logic        io_window_sel_i,
	input  wire logic        rw_i,
	input  wire logic        bus_strobe_i,
	input  wire logic [7:0]  data_i,
	input  wire logic [3:0]  board_number_switch_i,
	input  wire logic        slow_clk_jumper_i,
	input  wire logic        comparator_i,
	output logic [7:0]       data_o,
	output logic             data_oe_o,
	output logic             board_sel_o,
	output logic             buf_to_cpu_o,
	output logic             buf_to_adapter_o,
	output logic             conversion_go_o,
	output logic             output_enable_n_o,
	output logic             offset_null_phase_o,
	output logic             polarity_or_ramp_pos_o,
	output logic             ramp_neg_o,
	output logic             ramp_back_active_o,
	output logic             conversion_done_o,
	output logic [1:0]       mux_input_sel_o,
	output logic [4:0]       mux_enable_o,
	output logic             compensation_input_o,
	output logic [7:0]       data_channel_o
);

	// ****************************************
	// pin synchronisers
	// ****************************************
	// bit order: strobe, comparator, jumper, switch[3:0]
	logic [6:0] sync1_q, sync2_q, sync3_q, stable_q, stable_d;
	logic       strobe_s, comp_s, slow_s;
	logic [3:0] sw_s;

	always_comb begin
		// a bit moves only once the second and third stages agree
		stable_d = (sync2_q & sync3_q) | (stable_q & (sync2_q | sync3_q));
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			sync1_q  <= 7'h00;
			sync2_q  <= 7'h00;
			sync3_q  <= 7'h00;
			stable_q <= 7'h00;
		end else begin
			sync1_q  <= {bus_strobe_i, comparator_i, slow_clk_jumper_i, board_number_switch_i};
			sync2_q  <= sync1_q;
			sync3_q  <= sync2_q;
			stable_q <= stable_d;
		end
	end

	assign strobe_s = stable_q[6];
	assign comp_s   = stable_q[5];
	assign slow_s   = stable_q[4];
	assign sw_s     = stable_q[3:0];

	// ****************************************
	// address decode
	// ****************************************
	logic       match;
	logic       strobe_prev_q;
	logic       access;
	logic [1:0] reg_ofs;

	always_comb begin
		// address bits equal the switch when every XOR of inverted switch is high
		match = io_window_sel_i &&
		        (addr_i[15:8] == `WINDOW_HIGH_BYTE) &&
		        (addr_i[7:6] == `WINDOW_A7_A6) &&
		        (&(addr_i[5:2] ^ ~sw_s));
	end

	assign access  = strobe_s && !strobe_prev_q && match;
	assign reg_ofs = addr_i[1:0];

	// ****************************************
	// adapter registers
	// ****************************************
	logic [7:0] ctrl_a_q, ctrl_a_d, ctrl_b_q, ctrl_b_d;
	logic [7:0] dir_a_q, dir_a_d, dir_b_q, dir_b_d;
	logic [7:0] sel_q, sel_d;
	logic       flag_q, flag_d;
	logic       oe_n_q, oe_n_d;
	logic       done_prev_q;
	logic       seq_done, seq_over, seq_pol;
	logic [11:0] seq_result;
	logic       results_on;
	logic [7:0] port_b_in;
	logic [7:0] rd_data;

	// outputs only present while enable is low and go is high
	assign results_on = !output_enable_n_o && conversion_go_o;
	assign port_b_in  = results_on ? {2'b00, seq_pol, seq_over, seq_result[11:8]} : 8'h00;

	always_comb begin
		unique case (reg_ofs)
			`OFS_RESULT_LOW: begin
				rd_data = ctrl_a_q[`CTRL_DATA_SEL_BIT] ?
				          (results_on ? seq_result[7:0] : 8'h00) : dir_a_q;
			end
			`OFS_FIRST_CTRL: begin
				rd_data = {flag_q, ctrl_a_q[6:0]};
			end
			`OFS_RESULT_HIGH_SEL: begin
				// direction bits choose between the select latch and the result lines
				rd_data = ctrl_b_q[`CTRL_DATA_SEL_BIT] ?
				          ((sel_q & dir_b_q) | (port_b_in & ~dir_b_q)) : dir_b_q;
			end
			`OFS_SECOND_CTRL: begin
				rd_data = ctrl_b_q;
			end
		endcase
	end

	always_comb begin
		ctrl_a_d = ctrl_a_q;
		ctrl_b_d = ctrl_b_q;
		dir_a_d  = dir_a_q;
		dir_b_d  = dir_b_q;
		sel_d    = sel_q;
		flag_d   = flag_q;
		if (access && rw_i && reg_ofs == `OFS_RESULT_LOW && ctrl_a_q[`CTRL_DATA_SEL_BIT]) begin
			flag_d = 1'b0;
		end
		if (access && !rw_i) begin
			unique case (reg_ofs)
				`OFS_RESULT_LOW: begin
					if (!ctrl_a_q[`CTRL_DATA_SEL_BIT]) begin
						dir_a_d = data_i;
					end
				end
				`OFS_FIRST_CTRL: begin
					ctrl_a_d = {1'b0, data_i[6:0]};
				end
				`OFS_RESULT_HIGH_SEL: begin
					if (ctrl_b_q[`CTRL_DATA_SEL_BIT]) begin
						sel_d = data_i;
					end else begin
						dir_b_d = data_i;
					end
				end
				`OFS_SECOND_CTRL: begin
					ctrl_b_d = {1'b0, data_i[6:0]};
				end
			endcase
		end
		// a finish seen in the same cycle as the clearing read still raises the flag
		if (seq_done && !done_prev_q) begin
			flag_d = 1'b1;
		end
		// kept as its own flop so the pin is not an inverter output
		oe_n_d = !ctrl_b_d[`CTRL_OE_BIT];
	end

	// ****************************************
	// bus answer
	// ****************************************
	logic [7:0] data_q, data_d;
	logic       oe_q, oe_d, bsel_q, bsel_d, to_cpu_q, to_cpu_d, to_adp_q, to_adp_d;

	always_comb begin
		bsel_d   = match && strobe_s;
		to_cpu_d = bsel_d && rw_i;
		to_adp_d = bsel_d && !rw_i;
		oe_d     = to_cpu_d;
		data_d   = data_q;
		if (access && rw_i) begin
			data_d = rd_data;
		end
	end

	// ****************************************
	// input select and channel
	// ****************************************
	logic [1:0] mux_sel_q, mux_sel_d;
	logic [4:0] mux_en_q, mux_en_d;
	logic       comp_in_q, comp_in_d;
	logic [7:0] chan_q, chan_d;
	logic [4:0] in_index;

	// select lines only reach the multiplexers when set as outputs
	assign in_index = sel_q[4:0] & dir_b_q[4:0];

	always_comb begin
		mux_sel_d = in_index[1:0];
		comp_in_d = (in_index >= `SEL_COMP_FIRST) && (in_index < 5'h14);
		chan_d    = comp_in_d ? 8'h00 :
		            ({sw_s, 4'h0} + {4'h0, in_index[3:0]});
	end

	genvar m;
	generate
		for (m = 0; m < `MUX_COUNT; m++) begin : g_mux_en
			always_comb begin
				mux_en_d[m] = (in_index[4:2] == 3'(m));
			end
		end
	endgenerate

	// ****************************************
	// register stage
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			strobe_prev_q <= 1'b0;
			ctrl_a_q      <= `CTRL_RESET;
			ctrl_b_q      <= `CTRL_RESET;
			dir_a_q       <= `CTRL_RESET;
			dir_b_q       <= `CTRL_RESET;
			sel_q         <= `SEL_RESET;
			flag_q        <= 1'b0;
			oe_n_q        <= 1'b1;
			done_prev_q   <= 1'b0;
			data_q        <= 8'h00;
			oe_q          <= 1'b0;
			bsel_q        <= 1'b0;
			to_cpu_q      <= 1'b0;
			to_adp_q      <= 1'b0;
			mux_sel_q     <= 2'h0;
			mux_en_q      <= 5'h00;
			comp_in_q     <= 1'b0;
			chan_q        <= 8'h00;
		end else begin
			strobe_prev_q <= strobe_s;
			ctrl_a_q      <= ctrl_a_d;
			ctrl_b_q      <= ctrl_b_d;
			dir_a_q       <= dir_a_d;
			dir_b_q       <= dir_b_d;
			sel_q         <= sel_d;
			flag_q        <= flag_d;
			oe_n_q        <= oe_n_d;
			done_prev_q   <= seq_done;
			data_q        <= data_d;
			oe_q          <= oe_d;
			bsel_q        <= bsel_d;
			to_cpu_q      <= to_cpu_d;
			to_adp_q      <= to_adp_d;
			mux_sel_q     <= mux_sel_d;
			mux_en_q      <= mux_en_d;
			comp_in_q     <= comp_in_d;
			chan_q        <= chan_d;
		end
	end

	// ****************************************
	// converter controller
	// ****************************************
	adc_sequencer u_seq (
		.clk_i                  (clk_i),
		.sys_rst_i              (sys_rst_i),
		.slow_i                 (slow_s),
		.go_i                   (ctrl_a_q[`CTRL_GO_BIT]),
		.oe_n_i                 (!ctrl_b_q[`CTRL_OE_BIT]),
		.comp_i                 (comp_s),
		.offset_null_phase_o    (offset_null_phase_o),
		.polarity_or_ramp_pos_o (polarity_or_ramp_pos_o),
		.ramp_neg_o             (ramp_neg_o),
		.ramp_back_active_o     (ramp_back_active_o),
		.done_o                 (seq_done),
		.result_o               (seq_result),
		.over_o                 (seq_over),
		.polarity_o             (seq_pol)
	);

	assign data_o               = data_q;
	assign data_oe_o            = oe_q;
	assign board_sel_o          = bsel_q;
	assign buf_to_cpu_o         = to_cpu_q;
	assign buf_to_adapter_o     = to_adp_q;
	assign conversion_go_o      = ctrl_a_q[`CTRL_GO_BIT];
	assign output_enable_n_o    = oe_n_q;
	assign conversion_done_o    = seq_done;
	assign mux_input_sel_o      = mux_sel_q;
	assign mux_enable_o         = mux_en_q;
	assign compensation_input_o = comp_in_q;
	assign data_channel_o       = chan_q;

endmodule : analog_input_board

//--- analog_input_board_props.sv
// concurrent checks on the analog input board ports
`timescale 1ns/100ps
module analog_input_board_props (
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic [15:0] addr_i,
	input  wire logic        io_window_sel_i,
	input  wire logic        rw_i,
	input  wire logic [3:0]  board_number_switch_i,
	input  wire logic        slow_clk_jumper_i,
	input  wire logic        data_oe_o,
	input  wire logic        board_sel_o,
	input  wire logic        buf_to_cpu_o,
	input  wire logic        buf_to_adapter_o,
	input  wire logic        offset_null_phase_o,
	input  wire logic        polarity_or_ramp_pos_o,
	input  wire logic        ramp_neg_o,
	input  wire logic        ramp_back_active_o,
	input  wire logic        conversion_done_o,
	input  wire logic [4:0]  mux_enable_o,
	input  wire logic        compensation_input_o
);
	// ****************************************
	// phase length counters
	// ****************************************
	logic [15:0] null_cnt_q;
	logic [15:0] pos_cnt_q;
	logic [15:0] phase_len;
	// 256 ticks of 40 or 80 clocks
	assign phase_len = slow_clk_jumper_i ? 16'h5000 : 16'h2800;
	always_ff @(posedge clk_i) begin
		null_cnt_q <= (sys_rst_i || !offset_null_phase_o) ? 16'h0000 : null_cnt_q + 16'h0001;
		pos_cnt_q  <= (sys_rst_i || !polarity_or_ramp_pos_o) ? 16'h0000 : pos_cnt_q + 16'h0001;
	end
	// ****************************************
	// properties
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	property p_sel_match;
		board_sel_o |-> io_window_sel_i && addr_i[15:2] == {8'h81, 2'h1, board_number_switch_i};
	endproperty
	a_sel_match: assert property (p_sel_match) else $error("select on foreign address");
	property p_read_dir;
		board_sel_o && rw_i |-> buf_to_cpu_o && data_oe_o && !buf_to_adapter_o;
	endproperty
	a_read_dir: assert property (p_read_dir) else $error("read not toward cpu");
	property p_write_dir;
		buf_to_adapter_o |-> board_sel_o && !rw_i && !buf_to_cpu_o;
	endproperty
	a_write_dir: assert property (p_write_dir) else $error("bad write direction");
	property p_ramp_excl;
		!(polarity_or_ramp_pos_o && ramp_neg_o);
	endproperty
	a_ramp_excl: assert property (p_ramp_excl) else $error("both ramps high");
	property p_null_len;
		$fell(offset_null_phase_o) |-> null_cnt_q == phase_len;
	endproperty
	a_null_len: assert property (p_null_len) else $error("offset null length wrong");
	property p_pol_len;
		$fell(polarity_or_ramp_pos_o) && offset_null_phase_o |-> pos_cnt_q == phase_len;
	endproperty
	a_pol_len: assert property (p_pol_len) else $error("polarity length wrong");
	property p_order;
		$fell(offset_null_phase_o) |-> polarity_or_ramp_pos_o || ramp_neg_o;
	endproperty
	a_order: assert property (p_order) else $error("phase order wrong");
	property p_ramp_end;
		$fell(ramp_back_active_o) |-> conversion_done_o;
	endproperty
	a_ramp_end: assert property (p_ramp_end) else $error("no done after ramp");
	property p_mux_onehot;
		$onehot0(mux_enable_o);
	endproperty
	a_mux_onehot: assert property (p_mux_onehot) else $error("two muxes enabled");
	property p_comp;
		compensation_input_o |-> mux_enable_o == 5'h10;
	endproperty
	a_comp: assert property (p_comp) else $error("compensation on wrong mux");
endmodule : analog_input_board_props

bind analog_input_board analog_input_board_props u_props (
	.clk_i, .sys_rst_i, .addr_i, .io_window_sel_i, .rw_i, .board_number_switch_i,
	.slow_clk_jumper_i, .data_oe_o, .board_sel_o, .buf_to_cpu_o, .buf_to_adapter_o,
	.offset_null_phase_o, .polarity_or_ramp_pos_o, .ramp_neg_o, .ramp_back_active_o,
	.conversion_done_o, .mux_enable_o, .compensation_input_o
);

//--- cpu_partner.sv
// processor side of the parallel bus
`timescale 1ns/100ps
module cpu_partner (
	input  wire logic        clk_i,
	input  wire logic [7:0]  rd_data_i,
	input  wire logic        board_sel_i,
	output logic [15:0]      addr_o,
	output logic             io_sel_o,
	output logic             rw_o,
	output logic             strobe_o,
	output logic [7:0]       wr_data_o
);
	initial begin
		addr_o = 16'h0000;
		io_sel_o = 1'b0;
		rw_o = 1'b1;
		strobe_o = 1'b0;
		wr_data_o = 8'h00;
	end
	// the board resynchronises the strobe, so address and direction outlive it
	task automatic bus_cycle(input logic [15:0] a, input logic io, input logic rw,
		input logic [7:0] wd, output logic [7:0] rd, output logic sel);
		sel = 1'b0;
		@(posedge clk_i);
		addr_o <= a;
		io_sel_o <= io;
		rw_o <= rw;
		wr_data_o <= wd;
		strobe_o <= 1'b1;
		repeat (8) begin
			@(posedge clk_i);
			sel = sel | board_sel_i;
		end
		strobe_o <= 1'b0;
		repeat (7) begin
			@(posedge clk_i);
			sel = sel | board_sel_i;
		end
		rd = rd_data_i;
		// released bus shows the inverse, not the old value
		addr_o <= ~a;
		io_sel_o <= 1'b0;
		rw_o <= ~rw;
		wr_data_o <= ~wd;
	endtask : bus_cycle
endmodule : cpu_partner

//--- analog_input_board_bench.sv
// self-checking bench for the analog input board
`timescale 1ns/100ps
module analog_input_board_bench;
	localparam logic [15:0] BASE = 16'h814C;
	logic        clk_i, sys_rst_i, comp, strobe, io_sel, rw, sel;
	logic        data_oe, board_sel, to_cpu, to_adp, go, oe_n, null_ph, pos_ph, neg_ph;
	logic        back_ph, done, comp_in;
	logic [15:0] addr;
	logic [7:0]  wd, rd_bus, rd, chan;
	logic [3:0]  sw = 4'h3;
	logic        slow = 1'b0;
	logic [1:0]  msel;
	logic [4:0]  men;
	int          miscompares, compares, n;
	// select, mux select, enables, compensation, channel with the switch at 3
	logic [20:0] rows [6] = '{
		{5'h00, 2'h0, 5'h01, 1'b0, 8'h30}, {5'h07, 2'h3, 5'h02, 1'b0, 8'h37},
		{5'h0A, 2'h2, 5'h04, 1'b0, 8'h3A}, {5'h0F, 2'h3, 5'h08, 1'b0, 8'h3F},
		{5'h10, 2'h0, 5'h10, 1'b1, 8'h00}, {5'h13, 2'h3, 5'h10, 1'b1, 8'h00}};

	cpu_partner cpu (.clk_i(clk_i), .rd_data_i(rd_bus), .board_sel_i(board_sel), .addr_o(addr),
		.io_sel_o(io_sel), .rw_o(rw), .strobe_o(strobe), .wr_data_o(wd));
	analog_input_board uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr),
		.io_window_sel_i(io_sel), .rw_i(rw), .bus_strobe_i(strobe), .data_i(wd),
		.board_number_switch_i(sw), .slow_clk_jumper_i(slow), .comparator_i(comp),
		.data_o(rd_bus), .data_oe_o(data_oe), .board_sel_o(board_sel), .buf_to_cpu_o(to_cpu),
		.buf_to_adapter_o(to_adp), .conversion_go_o(go), .output_enable_n_o(oe_n),
		.offset_null_phase_o(null_ph), .polarity_or_ramp_pos_o(pos_ph), .ramp_neg_o(neg_ph),
		.ramp_back_active_o(back_ph), .conversion_done_o(done), .mux_input_sel_o(msel),
		.mux_enable_o(men), .compensation_input_o(comp_in), .data_channel_o(chan));

	// ****************************************
	// helpers
	// ****************************************
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic bus(input logic [15:0] a, input logic r, input logic [7:0] d);
		cpu.bus_cycle(a, 1'b1, r, d, rd, sel);
	endtask : bus
	// a slow phase lasts 20480 clocks, so 25000 is ample
	task automatic wait_null(input logic v);
		n = 0;
		while (null_ph !== v && n < 25000) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 25000) begin
			miscompares++;
			$display("MISMATCH phase wait expected %b seen timeout", v);
		end
	endtask : wait_null
	task automatic tally_and_finish;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : tally_and_finish

	// ****************************************
	// clock, watchdog, tests
	// ****************************************
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// whole run is about 73000 clocks, allow some margin
	initial begin
		#4500000;
		miscompares++;
		tally_and_finish;
	end
	initial begin
		sys_rst_i = 1'b1;
		comp = 1'b0;
		repeat (20) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		check("oe_n after reset", 8'h01, 8'(oe_n));
		check("go after reset", 8'h00, 8'(go));
		$display("test reset done");
		bus(BASE + 16'h0003, 1'b0, 8'h00);
		bus(BASE + 16'h0002, 1'b0, 8'h1F);
		bus(BASE + 16'h0003, 1'b0, 8'h04);
		foreach (rows[i]) begin
			bus(BASE + 16'h0002, 1'b0, {3'h0, rows[i][20:16]});
			bus(BASE + 16'h0002, 1'b1, 8'h00);
			check("select readback", {3'h0, rows[i][20:16]}, rd);
			check("read select", 8'h01, 8'(sel));
			check("mux input", 8'(rows[i][15:14]), 8'(msel));
			check("mux enable", 8'(rows[i][13:9]), 8'(men));
			check("compensation", 8'(rows[i][8]), 8'(comp_in));
			check("channel", rows[i][7:0], chan);
		end
		$display("test channel table done");
		bus(BASE + 16'h0006, 1'b0, 8'h00);
		check("neighbour slot select", 8'h00, 8'(sel));
		cpu.bus_cycle(BASE + 16'h0002, 1'b0, 1'b0, 8'h00, rd, sel);
		check("window off select", 8'h00, 8'(sel));
		check("mux kept", 8'h10, 8'(men));
		$display("test refusal done");
		bus(BASE + 16'h0001, 1'b0, 8'h04);
		bus(BASE, 1'b1, 8'h00);
		check("result with outputs off", 8'h00, rd);
		$display("test result gate done");
		comp <= 1'b1;
		bus(BASE + 16'h0001, 1'b0, 8'h0C);
		check("go", 8'h01, 8'(go));
		wait_null(1'b1);
		wait_null(1'b0);
		@(posedge clk_i);
		check("polarity phase", 8'h01, 8'(pos_ph));
		wait_null(1'b1);
		wait_null(1'b0);
		// init start was seen as it rose, so n is the whole phase: 256 ticks of 40 clocks
		check("init length", 8'h01, 8'(n == 10240));
		repeat (100) @(posedge clk_i);
		check("ramp positive", 8'h01, 8'(pos_ph));
		check("ramp negative", 8'h00, 8'(neg_ph));
		check("no done yet", 8'h00, 8'(done));
		$display("test conversion phases done");
		bus(BASE + 16'h0003, 1'b0, 8'h0C);
		check("oe_n driven low", 8'h00, 8'(oe_n));
		$display("test output enable done");
		// second reset in mid-conversion, then a run on the slow converter clock
		sys_rst_i <= 1'b1;
		slow      <= 1'b1;
		repeat (5) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		check("oe_n after reset 2", 8'h01, 8'(oe_n));
		check("ctrl after reset 2", 8'h00, 8'({null_ph, pos_ph, neg_ph, done}));
		bus(BASE + 16'h0001, 1'b0, 8'h08);
		wait_null(1'b1);
		wait_null(1'b0);
		wait_null(1'b1);
		// polarity phase seen whole: 256 ticks of 80 clocks
		check("slow polarity length", 8'h01, 8'(n == 20480));
		$display("test slow converter done");
		tally_and_finish;
	end
endmodule : analog_input_board_bench
